// ===== logic/dkuib_pkg.sv
package dkuib_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET       = 4'h2;
	localparam logic [3:0] KEY_STATUS_OFFSET = 4'h7;
	localparam logic [3:0] RESET_REQ_OFFSET  = 4'h8;
	localparam logic [3:0] SYS_STATUS_OFFSET = 4'hB;
	localparam logic [3:0] CRC_STATUS_OFFSET = 4'hC;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int GAP_ENABLE_BIT   = 7;
	localparam int GUARD_SEL_MSB    = 2;
	localparam int ROW_KEY_BIT      = 5;
	localparam int PROG_KEY_BIT     = 4;
	localparam int ERASE_KEY_BIT    = 3;
	localparam int RESET_SYS_BIT    = 5;
	localparam int PROG_STAT_BIT    = 3;
	localparam int ROW_STAT_BIT     = 2;
	localparam int ERASE_FAILED_BIT = 1;
	localparam int LOCK_STAT_BIT    = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] GUARD_SEL_RESET = 3'h0;
	localparam logic [7:0] RESET_REQ_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Key signatures and transfer sizes
	// ----------------------------------------------------------------
	localparam logic [63:0] ERASE_KEY_SIG = 64'h4E56_4D45_7261_7365;
	localparam logic [63:0] PROG_KEY_SIG  = 64'h4E56_4D50_726F_6720;
	localparam logic [63:0] ROW_KEY_SIG   = 64'h4E56_4D55_7326_7465;
	localparam logic [4:0]  KEY_BYTES     = 5'h08;
	localparam logic [4:0]  INFO_BYTES    = 5'h10;

	// ----------------------------------------------------------------
	// Timing counts in bit times
	// ----------------------------------------------------------------
	localparam logic [7:0] GAP_IDLE_BITS  = 8'h02;
	localparam logic [7:0] GUARD_MAX_BITS = 8'h80;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RX_KEY,
		ST_TX_WAIT,
		ST_TX_SEND
	} dkuib_state_type;

endpackage

// ===== logic/dkuib_core.sv
// Notes on behaviour
// - Keys are exactly 64 bits long
// - Information block up to 128 bits returned
// - Size operand sets count of byte frames
// - No response frame after a key
// - Information output starts after guard time
// - Gap enable inserts two idle bits
// - No guard time between streamed output bytes
// - Information block ignores lock bits
// - Block layout: family, versions, oscillator byte
// - Three keys recognised by signature, LSB first
// - Erase key erases, stays until interface disable or reset
// - Programming key needs unlock, ends when done
// - Row key needs lock, cleared by write
// - Reset signature holds system reset, 0x00 releases
// - Erase-failed flag reads zero on success
// - Locked device blocks system bus access
// - Boot check result readable even when locked
module dkuib_core #(
	parameter logic [55:0] FAMILY_CODE   = 56'h4445_5649_4345_30, // Arbitrary value
	parameter logic [23:0] MEM_CTRL_VER  = 24'h503A_31,           // Arbitrary value
	parameter logic [23:0] DEBUG_VER     = 24'h443A_31,           // Arbitrary value
	parameter logic [7:0]  DEBUG_OSC     = 8'h33,                 // Arbitrary value
	parameter logic [7:0]  RESET_SIG     = 8'h59,                 // Arbitrary value
	parameter logic [7:0]  RESERVED_BYTE = 8'h20
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic                 clkEn,
	input  wire logic [3:0]           regAddr,
	input  wire logic [7:0]           regWrData,
	input  wire logic                 regWrStb,
	input  wire logic                 regRdStb,
	output logic      [7:0]           regRdData,
	input  wire logic                 keyStart,
	input  wire logic                 keyInfo,
	input  wire logic [4:0]           keySize,
	input  wire logic                 rxValid,
	input  wire logic [7:0]           rxByte,
	input  wire logic                 bitTick,
	input  wire logic                 txReady,
	output logic                      txValid,
	output logic      [7:0]           txByte,
	input  wire logic                 lockIn,
	input  wire logic                 eraseDoneIn,
	input  wire logic                 eraseFailIn,
	input  wire logic [2:0]           crcIn,
	input  wire logic                 ifaceDisable,
	output logic                      eraseStart,
	output logic                      sysReset,
	output logic                      busGrant,
	output logic                      progMode,
	output logic                      rowMode
);
	import dkuib_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		dkuib_state_type state;
		logic [4:0]      size;
		logic [4:0]      remain;
		logic [63:0]     shift;
		logic [7:0]      idleCnt;
		logic            gapEn;
		logic [2:0]      guardSel;
		logic            eraseKey;
		logic            progKey;
		logic            rowKey;
		logic            progStat;
		logic            rowStat;
		logic [7:0]      resetReq;
		logic            sysReset;
		logic            eraseStart;
		logic            eraseFail;
		logic            busGrant;
		logic [7:0]      rdData;
		logic            txValid;
		logic [7:0]      txByte;
	} dkuib_regs_type;

	dkuib_regs_type cur_ff;
	dkuib_regs_type nxt_cur;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Byte of the information block at a given index
	function automatic logic [7:0] infoByte(input logic [4:0] idx);
		logic [7:0] b;
		b = RESERVED_BYTE;
		case (idx)
			5'h00: b = FAMILY_CODE[7:0];
			5'h01: b = FAMILY_CODE[15:8];
			5'h02: b = FAMILY_CODE[23:16];
			5'h03: b = FAMILY_CODE[31:24];
			5'h04: b = FAMILY_CODE[39:32];
			5'h05: b = FAMILY_CODE[47:40];
			5'h06: b = FAMILY_CODE[55:48];
			5'h08: b = MEM_CTRL_VER[7:0];
			5'h09: b = MEM_CTRL_VER[15:8];
			5'h0A: b = MEM_CTRL_VER[23:16];
			5'h0B: b = DEBUG_VER[7:0];
			5'h0C: b = DEBUG_VER[15:8];
			5'h0D: b = DEBUG_VER[23:16];
			5'h0F: b = DEBUG_OSC;
			default: b = RESERVED_BYTE;
		endcase
		return b;
	endfunction

	// Guard time in bit times for a guard select code
	function automatic logic [7:0] guardBits(input logic [2:0] sel);
		return GUARD_MAX_BITS >> sel;
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	logic       keyDone;
	logic       relEdge;
	logic [4:0] nextIdx;

	always_comb begin
		nxt_cur = cur_ff;
		keyDone = 1'b0;
		relEdge = 1'b0;
		nextIdx = 5'h00;
		nxt_cur.eraseStart = 1'b0;
		nxt_cur.rdData = 8'h00;
		nxt_cur.busGrant = ~lockIn;

		// Key and information transfer sequencer
		case (cur_ff.state)
			ST_IDLE: begin
				if (keyStart && keySize != 5'h00) begin
					if (keyInfo) begin
						// Size is capped at the block length
						nxt_cur.size = (keySize > INFO_BYTES) ? INFO_BYTES : keySize;
						nxt_cur.remain = nxt_cur.size;
						nxt_cur.idleCnt = guardBits(cur_ff.guardSel);
						nxt_cur.state = ST_TX_WAIT;
					end else begin
						nxt_cur.size = keySize;
						nxt_cur.remain = keySize;
						nxt_cur.state = ST_RX_KEY;
					end
				end
			end
			ST_RX_KEY: begin
				// Bytes arrive LSB first; no frame is sent back
				if (rxValid) begin
					nxt_cur.shift = {rxByte, cur_ff.shift[63:8]};
					nxt_cur.remain = cur_ff.remain - 5'h01;
					if (cur_ff.remain == 5'h01) begin
						keyDone = 1'b1;
						nxt_cur.state = ST_IDLE;
					end
				end
			end
			ST_TX_WAIT: begin
				// Idle bit times before the next output byte
				if (cur_ff.idleCnt == 8'h00) begin
					nxt_cur.txValid = 1'b1;
					nxt_cur.txByte = infoByte(cur_ff.size - cur_ff.remain);
					nxt_cur.state = ST_TX_SEND;
				end else if (bitTick) begin
					nxt_cur.idleCnt = cur_ff.idleCnt - 8'h01;
				end
			end
			ST_TX_SEND: begin
				if (txReady) begin
					nxt_cur.remain = cur_ff.remain - 5'h01;
					nextIdx = cur_ff.size - cur_ff.remain + 5'h01;
					if (cur_ff.remain == 5'h01) begin
						nxt_cur.txValid = 1'b0;
						nxt_cur.state = ST_IDLE;
					end else if (cur_ff.gapEn) begin
						nxt_cur.txValid = 1'b0;
						nxt_cur.idleCnt = GAP_IDLE_BITS;
						nxt_cur.state = ST_TX_WAIT;
					end else begin
						nxt_cur.txByte = infoByte(nextIdx);
					end
				end
			end
			default: begin
				nxt_cur.state = ST_IDLE;
				nxt_cur.txValid = 1'b0;
			end
		endcase

		// Register writes
		if (regWrStb) begin
			case (regAddr)
				CTRL_OFFSET: begin
					nxt_cur.gapEn = regWrData[GAP_ENABLE_BIT];
					nxt_cur.guardSel = regWrData[GUARD_SEL_MSB:0];
				end
				KEY_STATUS_OFFSET: begin
					if (regWrData[ROW_KEY_BIT]) begin
						nxt_cur.rowKey = 1'b0;
						nxt_cur.rowStat = 1'b0;
					end
				end
				RESET_REQ_OFFSET: begin
					nxt_cur.resetReq = regWrData;
					nxt_cur.sysReset = (regWrData == RESET_SIG);
				end
				default: begin
				end
			endcase
		end

		// Reset release: programming entry, completion and row entry
		relEdge = cur_ff.sysReset && !nxt_cur.sysReset;
		if (relEdge) begin
			if (cur_ff.progStat) begin
				nxt_cur.progKey = 1'b0;
				nxt_cur.progStat = 1'b0;
			end else if (cur_ff.progKey && !lockIn) begin
				nxt_cur.progStat = 1'b1;
			end
			if (cur_ff.rowKey && lockIn) begin
				nxt_cur.rowStat = 1'b1;
			end
		end

		// Erase launches when the system reset is taken with the key active
		if (!cur_ff.sysReset && nxt_cur.sysReset && cur_ff.eraseKey) begin
			nxt_cur.eraseStart = 1'b1;
			nxt_cur.eraseFail = 1'b0;
		end
		if (eraseDoneIn) begin
			nxt_cur.eraseFail = eraseFailIn;
		end

		// Key activation; setting wins over a same-cycle write or release clear, interface disable still drops the erase key
		if (keyDone && cur_ff.size == KEY_BYTES) begin
			if (nxt_cur.shift == ERASE_KEY_SIG) begin
				nxt_cur.eraseKey = 1'b1;
			end
			if (nxt_cur.shift == PROG_KEY_SIG) begin
				nxt_cur.progKey = 1'b1;
			end
			if (nxt_cur.shift == ROW_KEY_SIG) begin
				nxt_cur.rowKey = 1'b1;
			end
		end

		// Interface disable drops the erase key
		if (ifaceDisable) begin
			nxt_cur.eraseKey = 1'b0;
		end

		// Register reads, data valid in the following cycle only
		if (regRdStb) begin
			case (regAddr)
				CTRL_OFFSET: begin
					nxt_cur.rdData = {cur_ff.gapEn, 4'h0, cur_ff.guardSel};
				end
				KEY_STATUS_OFFSET: begin
					nxt_cur.rdData[ROW_KEY_BIT] = cur_ff.rowKey;
					nxt_cur.rdData[PROG_KEY_BIT] = cur_ff.progKey;
					nxt_cur.rdData[ERASE_KEY_BIT] = cur_ff.eraseKey;
				end
				RESET_REQ_OFFSET: begin
					nxt_cur.rdData = cur_ff.resetReq;
				end
				SYS_STATUS_OFFSET: begin
					nxt_cur.rdData[RESET_SYS_BIT] = cur_ff.sysReset;
					nxt_cur.rdData[PROG_STAT_BIT] = cur_ff.progStat;
					nxt_cur.rdData[ROW_STAT_BIT] = cur_ff.rowStat;
					nxt_cur.rdData[ERASE_FAILED_BIT] = cur_ff.eraseFail;
					nxt_cur.rdData[LOCK_STAT_BIT] = lockIn;
				end
				CRC_STATUS_OFFSET: begin
					nxt_cur.rdData = {5'h00, crcIn};
				end
				default: begin
					nxt_cur.rdData = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------

	// Clock enable freezes every field
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '{
				state:      ST_IDLE,
				size:       5'h00,
				remain:     5'h00,
				shift:      64'h0000_0000_0000_0000,
				idleCnt:    8'h00,
				gapEn:      1'b0,
				guardSel:   GUARD_SEL_RESET,
				eraseKey:   1'b0,
				progKey:    1'b0,
				rowKey:     1'b0,
				progStat:   1'b0,
				rowStat:    1'b0,
				resetReq:   RESET_REQ_RESET,
				sysReset:   1'b0,
				eraseStart: 1'b0,
				eraseFail:  1'b0,
				busGrant:   1'b0,
				rdData:     8'h00,
				txValid:    1'b0,
				txByte:     8'h00
			};
		end else if (clkEn) begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// All outputs are register fields
	assign regRdData  = cur_ff.rdData;
	assign txValid    = cur_ff.txValid;
	assign txByte     = cur_ff.txByte;
	assign eraseStart = cur_ff.eraseStart;
	assign sysReset   = cur_ff.sysReset;
	assign busGrant   = cur_ff.busGrant;
	assign progMode   = cur_ff.progStat;
	assign rowMode    = cur_ff.rowStat;

endmodule

// ===== test/dkuib_core_asserts.sv
module dkuib_core_asserts
	import dkuib_pkg::*;
#(
	parameter logic [7:0] RESET_SIG = 8'h59
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrStb,
	input wire logic       regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic       keyStart,
	input wire logic       keyInfo,
	input wire logic       bitTick,
	input wire logic       txReady,
	input wire logic       txValid,
	input wire logic [7:0] txByte,
	input wire logic       lockIn,
	input wire logic       eraseStart,
	input wire logic       sysReset,
	input wire logic       busGrant,
	input wire logic       progMode,
	input wire logic       rowMode
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------------------------------
	// Step sequences
	// ----------------------------------------------------------------
	sequence quietTx;
		!txValid [*8];
	endsequence
	sequence sysHold;
		$rose(sysReset);
	endsequence
	sequence pulseEnd;
		!eraseStart;
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_lock_read: assert property (
		$past(regRdStb) && $past(regAddr) == SYS_STATUS_OFFSET
		|-> regRdData[LOCK_STAT_BIT] == $past(lockIn)) else $error("lock flag read wrong");
	chk_bus_block: assert property (
		$past(rst_n) |-> busGrant == !$past(lockIn)) else $error("bus grant wrong");
	chk_key_silent: assert property (
		keyStart && !keyInfo && !txValid |=> quietTx) else $error("answer after key");
	chk_guard_tick: assert property (
		$rose(txValid) |-> $past(bitTick) || $past(bitTick, 2)) else $error("byte off bit time");
	chk_tx_hold: assert property (
		txValid && !txReady |=> txValid && $stable(txByte)) else $error("byte dropped");
	chk_erase_sync: assert property (
		eraseStart |-> sysHold ##1 pulseEnd) else $error("erase pulse wrong");
	chk_reset_req: assert property (
		regWrStb && regAddr == RESET_REQ_OFFSET
		|=> sysReset == ($past(regWrData) == RESET_SIG)) else $error("system reset wrong");
	chk_prog_unlock: assert property (
		$rose(progMode) |-> !$past(lockIn)) else $error("prog flag while locked");
	chk_row_lock: assert property (
		$rose(rowMode) |-> $past(lockIn)) else $error("row flag while unlocked");
endmodule

bind dkuib_core dkuib_core_asserts #(.RESET_SIG(RESET_SIG)) u_chk (.ref_clk(ref_clk),
	.rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
	.regRdStb(regRdStb), .regRdData(regRdData), .keyStart(keyStart), .keyInfo(keyInfo),
	.bitTick(bitTick), .txReady(txReady), .txValid(txValid), .txByte(txByte),
	.lockIn(lockIn), .eraseStart(eraseStart), .sysReset(sysReset), .busGrant(busGrant),
	.progMode(progMode), .rowMode(rowMode));

// ===== test/dkuib_phy_model.sv
module dkuib_phy_model #(
	parameter int TICK = 8
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic stall,
	output logic      bitTick,
	output logic      txReady
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_ff;

	// Bit pacing; a stalled host takes bytes only half the time
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= 8'h00;
			bitTick <= 1'b0;
			txReady <= 1'b0;
		end else begin
			cnt_ff <= (cnt_ff == 8'(TICK - 1)) ? 8'h00 : cnt_ff + 8'h01;
			bitTick <= (cnt_ff == 8'(TICK - 1));
			txReady <= !stall || cnt_ff[2];
		end
	end
endmodule

// ===== test/dkuib_core_tb.sv
module dkuib_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dkuib_pkg::*;
	localparam int TICK = 8;
	localparam logic [7:0] RSIG = 8'h59;
	localparam logic [127:0] infoBlock = {8'h4B, 8'h20, 24'h4456_31, 24'h4D43_31, 8'h20,
		56'h5445_5354_4641_4D};
	logic ref_clk = 0, rst_n = 0, clkEn = 1, regWrStb = 0, regRdStb = 0, keyStart = 0;
	logic keyInfo = 0, rxValid = 0, lockIn = 1, eraseDoneIn = 0, eraseFailIn = 0;
	logic ifaceDisable = 0, stall = 0, bitTick, txReady, txValid;
	logic eraseStart, sysReset, busGrant, progMode, rowMode;
	logic [3:0] regAddr = 4'h0;
	logic [4:0] keySize = 5'h00;
	logic [2:0] crcIn = 3'h5;
	logic [7:0] regWrData = 8'h00, rxByte = 8'h00, st, txByte, regRdData;
	int         n_errors = 0, checks_done = 0, lat, s, f;

	always #25 ref_clk = ~ref_clk;

	dkuib_core #(.FAMILY_CODE(infoBlock[55:0]), .MEM_CTRL_VER(infoBlock[87:64]),
		.DEBUG_VER(infoBlock[111:88]), .DEBUG_OSC(infoBlock[127:120]), .RESET_SIG(RSIG),
		.RESERVED_BYTE(8'h20)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .keyStart(keyStart), .keyInfo(keyInfo), .keySize(keySize),
		.rxValid(rxValid), .rxByte(rxByte), .bitTick(bitTick), .txReady(txReady),
		.txValid(txValid), .txByte(txByte), .lockIn(lockIn), .eraseDoneIn(eraseDoneIn),
		.eraseFailIn(eraseFailIn), .crcIn(crcIn), .ifaceDisable(ifaceDisable),
		.eraseStart(eraseStart), .sysReset(sysReset), .busGrant(busGrant),
		.progMode(progMode), .rowMode(rowMode));
	dkuib_phy_model #(.TICK(TICK)) phy (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
		.bitTick(bitTick), .txReady(txReady));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task finish_test;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrStb <= 1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrStb <= 0;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		regRdStb <= 1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdStb <= 0;
		@(negedge ref_clk);
		d = regRdData;
	endtask
	// Key bytes go out lowest byte first
	task key(input logic [63:0] sig, input logic [4:0] n);
		@(posedge ref_clk);
		keyStart <= 1;
		keyInfo <= 0;
		keySize <= n;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			keyStart <= 0;
			rxValid <= 1;
			rxByte <= sig[8*i+:8];
		end
		@(posedge ref_clk);
		rxValid <= 0;
		repeat (2) @(posedge ref_clk);
	endtask
	// Info request; collects bytes, guard latency and spacing
	task info(input logic [4:0] n, input logic gap);
		int i, t, last;
		@(posedge ref_clk);
		keyStart <= 1;
		keyInfo <= 1;
		keySize <= n;
		@(posedge ref_clk);
		keyStart <= 0;
		i = 0;
		last = 0;
		for (t = 1; t < 9000 && i < n; t++) begin
			@(negedge ref_clk);
			if (txValid === 1'b1 && txReady === 1'b1) begin
				if (i == 0) lat = t;
				check("info byte", txByte, infoBlock[8*i+:8]);
				// Two counted bit ticks: at least one full bit time plus the tick phase
				if (i > 0) check("spacing", {7'h0, gap ? t - last >= (GAP_IDLE_BITS - 1) * TICK + 2
					: t - last <= 2}, 8'h01);
				last = t;
				i++;
			end
		end
		if (i < n) begin
			n_errors++;
			finish_test();
		end
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		check("extra byte", {7'h0, txValid}, 8'h00);
	endtask
	task rstPulse;
		wr(RESET_REQ_OFFSET, RSIG);
		rd(SYS_STATUS_OFFSET, st);
		check("held reset", st & 8'h20, 8'h20);
		wr(RESET_REQ_OFFSET, 8'h00);
		repeat (2) @(posedge ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1;
		rd(CTRL_OFFSET, st);
		check("ctrl reset", st, 8'h00);
		rd(CRC_STATUS_OFFSET, st);
		check("crc locked", st, 8'h05);
		rd(4'h5, st);
		check("unmapped", st, 8'h00);
		check("bus blocked", {7'h0, busGrant}, 8'h00);
		for (s = 0; s < 8; s++) begin
			wr(CTRL_OFFSET, 8'(s));
			info(5'h01, 1'b0);
			check("guard", {7'h0, lat >= ((128 >> s) - 1) * TICK && lat <= ((128 >> s) + 1) * TICK + 4}, 8'h01);
		end
		wr(CTRL_OFFSET, 8'h07);
		info(5'h10, 1'b0);
		stall <= 1;
		wr(CTRL_OFFSET, 8'h87);
		info(5'h08, 1'b1);
		stall <= 0;
		key(ROW_KEY_SIG ^ 64'h1, 5'h08);
		key(ERASE_KEY_SIG, 5'h07);
		rd(KEY_STATUS_OFFSET, st);
		check("bad keys", st & 8'h38, 8'h00);
		key(ERASE_KEY_SIG, 5'h08);
		rd(KEY_STATUS_OFFSET, st);
		check("erase key", st & 8'h38, 8'h08);
		for (f = 1; f >= 0; f--) begin
			rstPulse();
			@(posedge ref_clk);
			eraseDoneIn <= 1;
			eraseFailIn <= f[0];
			lockIn <= f[0];
			@(posedge ref_clk);
			eraseDoneIn <= 0;
			rd(SYS_STATUS_OFFSET, st);
			check("erase failed", st & 8'h02, {6'h0, f[0], 1'b0});
		end
		for (s = 0; s < 20 && st[0] !== 1'b0; s++) rd(SYS_STATUS_OFFSET, st);
		check("unlocked", st & 8'h01, 8'h00);
		if (st[0] !== 1'b0) finish_test();
		check("bus open", {7'h0, busGrant}, 8'h01);
		key(PROG_KEY_SIG, 5'h08);
		rstPulse();
		rd(SYS_STATUS_OFFSET, st);
		check("prog on", st & 8'h08, 8'h08);
		rstPulse();
		rd(SYS_STATUS_OFFSET, st);
		check("prog done", st & 8'h08, 8'h00);
		@(posedge ref_clk);
		lockIn <= 1;
		key(PROG_KEY_SIG, 5'h08);
		rstPulse();
		rd(SYS_STATUS_OFFSET, st);
		check("prog locked", st & 8'h08, 8'h00);
		key(ROW_KEY_SIG, 5'h08);
		rstPulse();
		rd(SYS_STATUS_OFFSET, st);
		check("row on", st & 8'h04, 8'h04);
		wr(KEY_STATUS_OFFSET, 8'h20);
		rd(KEY_STATUS_OFFSET, st);
		check("row cleared", st & 8'h28, 8'h08);
		rd(SYS_STATUS_OFFSET, st);
		check("row off", st & 8'h04, 8'h00);
		@(posedge ref_clk);
		ifaceDisable <= 1;
		@(posedge ref_clk);
		ifaceDisable <= 0;
		rd(KEY_STATUS_OFFSET, st);
		check("erase dropped", st & 8'h08, 8'h00);
		// A write while the clock enable is low must not land
		@(posedge ref_clk);
		clkEn <= 0;
		wr(CTRL_OFFSET, 8'h01);
		@(posedge ref_clk);
		clkEn <= 1;
		rd(CTRL_OFFSET, st);
		check("frozen ctrl", st, 8'h87);
		finish_test();
	end
endmodule
